/* dv/dfc_cfg_host.sv */
// partner model: upstream requester issuing configuration reads and writes
`timescale 1ns/1ns
`default_nettype none
module dfc_cfg_host (
    input  wire logic                clk_sys_i,
    output dfc_pkg::dfc_cfg_req_type cfg_req_o
);
    initial cfg_req_o = '0;

    // ------------------------------------------------------------------
    // one request, held for exactly the taking edge
    // ------------------------------------------------------------------
    // idle fields are inverted so a stale value is never mistaken for a live one
    task automatic access(input logic wr, input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd);
        @(posedge clk_sys_i);
        cfg_req_o <= {1'b1, wr, dw, be, wd};
        @(posedge clk_sys_i);
        cfg_req_o <= {1'b0, ~wr, ~dw, ~be, ~wd};
    endtask
endmodule // dfc_cfg_host
`default_nettype wire

/* dv/dfc_header_status_tb_top.sv */
// testbench: scoreboard checks of the dma function header status registers
`timescale 1ns/1ns
`default_nettype none
module dfc_header_status_tb_top;
    localparam logic [7:0] REV = 8'h5A;  // arbitrary revision value
    logic                     clk_sys_i, rst_i, por_rst_i, cfg_ack, allow;
    logic                     intx, pe, se, de, lock;
    logic [31:0]              cfg_rdata, cc;
    logic [15:0]              sts, m;
    logic [7:0]               line_size, c;
    dfc_pkg::dfc_cfg_req_type cfg_req;
    dfc_pkg::dfc_event_type   ev, e;
    logic [32:0]              notes[$];
    logic [32:0]              note;
    int                       fail_count, comparisons, cycles;
    int                       seed = 32'h432957db;

    dfc_cfg_host i_dfc_cfg_host (.clk_sys_i(clk_sys_i), .cfg_req_o(cfg_req));
    dfc_header_status #(.REVISION_RESET(REV)) i_dfc_header_status (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .por_rst_i(por_rst_i),
        .cfg_req_i(cfg_req), .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
        .event_i(ev), .intx_pending_i(intx), .parity_report_enable_i(pe),
        .system_error_report_enable_i(se), .devctl_error_report_enable_i(de),
        .cfg_lock_i(lock), .error_report_allow_o(allow), .cache_line_size_o(line_size));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [9:0] dw, input logic [31:0] exp);
        notes.push_back({1'b1, exp});
        i_dfc_cfg_host.access(1'b0, dw, 4'h0, 32'h0);
    endtask
    task automatic wr(input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd);
        notes.push_back({1'b0, 32'h0});
        i_dfc_cfg_host.access(1'b1, dw, be, wd);
    endtask
    task automatic pulse(input dfc_pkg::dfc_event_type pe_ev);
        @(posedge clk_sys_i);
        ev <= pe_ev;
        @(posedge clk_sys_i);
        ev <= '0;
    endtask
    // status word as software sees it: flags, intx copy, fixed capability bit
    function automatic logic [31:0] st();
        return {sts | {11'h000, 1'b1, intx, 3'h0}, 16'h0000};
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // monitor and watchdog
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cfg_ack === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("unexpected cfg_ack: expected none seen 1");
            end else begin
                note = notes.pop_front();
                if (note[32]) check("cfg_rdata", cfg_rdata, note[31:0]);
            end
        end
        if (cycles == 5000) begin
            fail_count++;
            $display("unexpected timeout: expected done seen hang");
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        por_rst_i = 1'b1;
        ev = '0;
        {intx, pe, se, de, lock} = '0;
        sts = '0;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        por_rst_i <= 1'b0;
        rd(10'h001, st());
        rd(10'h002, {24'h088000, REV});
        rd(10'h003, 32'h0080_0000);
        rd(10'h3FF, 32'h0);
        wr(10'h3FF, 4'hF, 32'hFFFF_FFFF);
        $display("test reset values done");
        // random events and enables, then write-zero, then random clear mask
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            {intx, pe, se, de} <= 4'($random(seed));
            e = 6'($random(seed));
            if (e.poisoned_cpl_rx) e.poisoned_tlp_rx = 1'b1;
            pulse(e);
            check("allow", {31'h0, allow}, {31'h0, se | de});
            sts[8] = sts[8] | (pe & (e.poisoned_cpl_rx | e.poisoned_req_tx));
            sts[12] = sts[12] | e.cpl_abort_rx;
            sts[13] = sts[13] | e.cpl_unsupported_rx;
            sts[14] = sts[14] | (se & e.err_msg_tx);
            sts[15] = sts[15] | e.poisoned_tlp_rx;
            rd(10'h001, st());
            wr(10'h001, 4'hC, 32'h0);
            rd(10'h001, st());
            m = 16'($random(seed));
            wr(10'h001, 4'hC, {m, 16'h0000});
            sts = sts & ~m;
            rd(10'h001, st());
        end
        // set wins over a clear landing on the same edge
        e = '0;
        e.cpl_abort_rx = 1'b1;
        fork
            wr(10'h001, 4'h8, 32'h1000_0000);
            pulse(e);
        join
        sts[12] = 1'b1;
        rd(10'h001, st());
        $display("test status flags done");
        c = 8'($random(seed));
        wr(10'h003, 4'hF, {24'hFFFFFF, c});
        rd(10'h003, {24'h008000, c});
        check("cache_line_size", {24'h0, line_size}, {24'h0, c});
        lock <= 1'b1;
        wr(10'h002, 4'hF, 32'hFFFF_FFFF);
        rd(10'h002, {24'h088000, REV});
        lock <= 1'b0;
        cc = $random(seed);
        wr(10'h002, 4'hF, cc);
        wr(10'h002, 4'h1, ~cc);
        rd(10'h002, {cc[31:8], ~cc[7:0]});
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        sts = '0;
        rd(10'h002, {cc[31:8], ~cc[7:0]});
        rd(10'h003, 32'h0080_0000);
        rd(10'h001, st());
        repeat (2) @(posedge clk_sys_i);
        {rst_i, por_rst_i} <= 2'b11;
        repeat (2) @(posedge clk_sys_i);
        {rst_i, por_rst_i} <= 2'b00;
        rd(10'h002, {24'h088000, REV});
        repeat (3) @(posedge clk_sys_i);
        check("pending_notes", notes.size(), 32'h0);
        $display("test lock and resets done");
        end_of_test();
    end
endmodule // dfc_header_status_tb_top
`default_nettype wire

/* rtl/dfc_header_status.sv */
// dma function header status, class, revision and header type registers
`timescale 1ns/1ns
`default_nettype none
module dfc_header_status #(
    parameter logic [7:0] REVISION_RESET = 8'h01  // arbitrary value, set per implementation
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire logic                     por_rst_i,
    input  wire dfc_pkg::dfc_cfg_req_type cfg_req_i,
    output logic                          cfg_ack_o,
    output logic [31:0]                   cfg_rdata_o,
    input  wire dfc_pkg::dfc_event_type   event_i,
    input  wire logic                     intx_pending_i,
    input  wire logic                     parity_report_enable_i,
    input  wire logic                     system_error_report_enable_i,
    input  wire logic                     devctl_error_report_enable_i,
    input  wire logic                     cfg_lock_i,
    output logic                          error_report_allow_o,
    output logic [7:0]                    cache_line_size_o
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        sel_status;
    logic        sel_rev_class;
    logic        sel_line_header;
    logic        wr;
    logic        rd;
    logic [15:0] status_clr;
    logic [15:0] function_status;
    logic [7:0]  revision_number;
    logic [23:0] class_code;
    logic [7:0]  cache_line_size_r;
    logic        master_parity_error_flag;
    logic        received_completer_abort_flag;
    logic        received_unsupported_flag;
    logic        signaled_system_error_flag;
    logic        poisoned_packet_seen_flag;
    logic        master_parity_set;
    logic        system_error_set;

    assign sel_status    = cfg_req_i.dword == dfc_pkg::DW_CMD_STATUS;
    assign sel_rev_class = cfg_req_i.dword == dfc_pkg::DW_REV_CLASS;
    assign sel_line_header = cfg_req_i.dword == dfc_pkg::DW_LINE_HEADER;
    assign wr            = cfg_req_i.valid && cfg_req_i.write;
    assign rd            = cfg_req_i.valid && !cfg_req_i.write;

    // write-one-to-clear strobes per status bit, gated by its byte lane
    always_comb begin
        status_clr = 16'h0000;
        if (wr && sel_status) begin
            if (cfg_req_i.byte_en[dfc_pkg::LANE_STATUS_LO]) begin
                status_clr[7:0] = cfg_req_i.wdata[23:16];
            end
            if (cfg_req_i.byte_en[dfc_pkg::LANE_STATUS_HI]) begin
                status_clr[15:8] = cfg_req_i.wdata[31:24];
            end
        end
    end

    // ------------------------------------------------------------------
    // error flags
    // ------------------------------------------------------------------
    assign master_parity_set = parity_report_enable_i &&
                               (event_i.poisoned_cpl_rx || event_i.poisoned_req_tx);
    assign system_error_set  = event_i.err_msg_tx && system_error_report_enable_i;

    dfc_w1c_flag u_master_parity (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (master_parity_set),
        .clr_i     (status_clr[dfc_pkg::STS_MASTER_PARITY]),
        .flag_o    (master_parity_error_flag)
    );

    dfc_w1c_flag u_rx_cpl_abort (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (event_i.cpl_abort_rx),
        .clr_i     (status_clr[dfc_pkg::STS_RX_CPL_ABORT]),
        .flag_o    (received_completer_abort_flag)
    );

    dfc_w1c_flag u_rx_unsupported (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (event_i.cpl_unsupported_rx),
        .clr_i     (status_clr[dfc_pkg::STS_RX_UNSUPP]),
        .flag_o    (received_unsupported_flag)
    );

    dfc_w1c_flag u_sig_sys_err (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (system_error_set),
        .clr_i     (status_clr[dfc_pkg::STS_SIG_SYS_ERR]),
        .flag_o    (signaled_system_error_flag)
    );

    dfc_w1c_flag u_poison_seen (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (event_i.poisoned_tlp_rx),
        .clr_i     (status_clr[dfc_pkg::STS_POISON_SEEN]),
        .flag_o    (poisoned_packet_seen_flag)
    );

    // the link layer still needs its own gating by message type
    assign error_report_allow_o = system_error_report_enable_i || devctl_error_report_enable_i;

    // ------------------------------------------------------------------
    // status image
    // ------------------------------------------------------------------
    always_comb begin
        function_status                              = 16'h0000;
        function_status[dfc_pkg::STS_INTX_PENDING]   = intx_pending_i;
        function_status[dfc_pkg::STS_CAP_LIST]       = dfc_pkg::CAP_LIST_VALUE[0];
        function_status[dfc_pkg::STS_MASTER_PARITY]  = master_parity_error_flag;
        function_status[dfc_pkg::STS_SIGNALED_ABT]   = 1'b0;
        function_status[dfc_pkg::STS_RX_CPL_ABORT]   = received_completer_abort_flag;
        function_status[dfc_pkg::STS_RX_UNSUPP]      = received_unsupported_flag;
        function_status[dfc_pkg::STS_SIG_SYS_ERR]    = signaled_system_error_flag;
        function_status[dfc_pkg::STS_POISON_SEEN]    = poisoned_packet_seen_flag;
    end

    // ------------------------------------------------------------------
    // revision and class code
    // ------------------------------------------------------------------
    dfc_lock_byte #(
        .RESET_VAL (REVISION_RESET)
    ) u_revision (
        .clk_sys_i (clk_sys_i),
        .por_rst_i (por_rst_i),
        .we_i      (wr && sel_rev_class && cfg_req_i.byte_en[dfc_pkg::LANE_REV]),
        .lock_i    (cfg_lock_i),
        .wdata_i   (cfg_req_i.wdata[7:0]),
        .q_o       (revision_number)
    );

    dfc_lock_byte #(
        .RESET_VAL (dfc_pkg::PROG_IF_RESET)
    ) u_prog_if (
        .clk_sys_i (clk_sys_i),
        .por_rst_i (por_rst_i),
        .we_i      (wr && sel_rev_class && cfg_req_i.byte_en[dfc_pkg::LANE_PROG_IF]),
        .lock_i    (cfg_lock_i),
        .wdata_i   (cfg_req_i.wdata[15:8]),
        .q_o       (class_code[7:0])
    );

    dfc_lock_byte #(
        .RESET_VAL (dfc_pkg::SUBCLASS_RESET)
    ) u_subclass (
        .clk_sys_i (clk_sys_i),
        .por_rst_i (por_rst_i),
        .we_i      (wr && sel_rev_class && cfg_req_i.byte_en[dfc_pkg::LANE_SUBCLASS]),
        .lock_i    (cfg_lock_i),
        .wdata_i   (cfg_req_i.wdata[23:16]),
        .q_o       (class_code[15:8])
    );

    dfc_lock_byte #(
        .RESET_VAL (dfc_pkg::BASE_CLASS_RESET)
    ) u_base_class (
        .clk_sys_i (clk_sys_i),
        .por_rst_i (por_rst_i),
        .we_i      (wr && sel_rev_class && cfg_req_i.byte_en[dfc_pkg::LANE_BASE_CLASS]),
        .lock_i    (cfg_lock_i),
        .wdata_i   (cfg_req_i.wdata[31:24]),
        .q_o       (class_code[23:16])
    );

    // ------------------------------------------------------------------
    // cache line size
    // ------------------------------------------------------------------
    // stored for software and driven out on cache_line_size_o; nothing inside consumes it
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cache_line_size_r <= dfc_pkg::LINE_SIZE_RESET;
        end else if (wr && sel_line_header && cfg_req_i.byte_en[dfc_pkg::LANE_LINE_SIZE]) begin
            cache_line_size_r <= cfg_req_i.wdata[7:0];
        end
    end
    assign cache_line_size_o = cache_line_size_r;

    // ------------------------------------------------------------------
    // read path, one cycle after the request
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_ack_o <= 1'b0;
        end else begin
            cfg_ack_o <= cfg_req_i.valid;
        end
    end

    // command half of the status dword belongs to the neighbouring block and reads zero here
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_rdata_o <= dfc_pkg::UNMAPPED_VALUE;
        end else if (rd) begin
            if (sel_status) begin
                cfg_rdata_o <= {function_status, 16'h0000};
            end else if (sel_rev_class) begin
                cfg_rdata_o <= {class_code, revision_number};
            end else if (sel_line_header) begin
                cfg_rdata_o <= {dfc_pkg::BIST_VALUE, dfc_pkg::HEADER_TYPE_VALUE,
                                dfc_pkg::LATENCY_VALUE, cache_line_size_r};
            end else begin
                cfg_rdata_o <= dfc_pkg::UNMAPPED_VALUE;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_intx_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        (rd && sel_status) |=> cfg_rdata_o[16 + dfc_pkg::STS_INTX_PENDING] == $past(intx_pending_i);
    endproperty
    a_intx_read: assert property (p_intx_read) else $error("intx pending bit misreported");

    property p_cap_list;
        @(posedge clk_sys_i) disable iff (rst_i)
        (rd && sel_status) |=> cfg_rdata_o[16 + dfc_pkg::STS_CAP_LIST] && cfg_ack_o;
    endproperty
    a_cap_list: assert property (p_cap_list) else $error("capability list bit not one");

    property p_parity_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        (parity_report_enable_i && event_i.poisoned_req_tx) |=> master_parity_error_flag;
    endproperty
    a_parity_set: assert property (p_parity_set) else $error("master parity flag not set");

    property p_parity_gated;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!parity_report_enable_i && !master_parity_error_flag) |=> !master_parity_error_flag;
    endproperty
    a_parity_gated: assert property (p_parity_gated) else $error("parity flag set while disabled");

    property p_cpl_abort;
        @(posedge clk_sys_i) disable iff (rst_i)
        event_i.cpl_abort_rx |=> received_completer_abort_flag [*1] ##0 !received_unsupported_flag || $past(event_i.cpl_unsupported_rx) || $past(received_unsupported_flag);
    endproperty
    a_cpl_abort: assert property (p_cpl_abort) else $error("completer abort flag wrong");

    property p_unsupported;
        @(posedge clk_sys_i) disable iff (rst_i)
        event_i.cpl_unsupported_rx |=> received_unsupported_flag;
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("unsupported flag not set");

    property p_sys_err;
        @(posedge clk_sys_i) disable iff (rst_i)
        (event_i.err_msg_tx && !system_error_report_enable_i && !signaled_system_error_flag)
            |=> !signaled_system_error_flag;
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error flag set while disabled");

    property p_poison_seen;
        @(posedge clk_sys_i) disable iff (rst_i)
        event_i.poisoned_tlp_rx |=> poisoned_packet_seen_flag ##1 (poisoned_packet_seen_flag || $past(status_clr[dfc_pkg::STS_POISON_SEEN]));
    endproperty
    a_poison_seen: assert property (p_poison_seen) else $error("poison flag not held");

    property p_w1c_clear;
        @(posedge clk_sys_i) disable iff (rst_i)
        (status_clr[dfc_pkg::STS_RX_CPL_ABORT] && !event_i.cpl_abort_rx) |=> !received_completer_abort_flag;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear flag");

    property p_fixed_bytes;
        @(posedge clk_sys_i) disable iff (rst_i)
        (rd && sel_line_header) |=> cfg_rdata_o[23:16] == dfc_pkg::HEADER_TYPE_VALUE &&
                                    cfg_rdata_o[15:8] == dfc_pkg::LATENCY_VALUE;
    endproperty
    a_fixed_bytes: assert property (p_fixed_bytes) else $error("header type or latency wrong");

    property p_cls_write;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr && sel_line_header && cfg_req_i.byte_en[dfc_pkg::LANE_LINE_SIZE]) |=>
            cache_line_size_o == $past(cfg_req_i.wdata[7:0]);
    endproperty
    a_cls_write: assert property (p_cls_write) else $error("cache line size not written");

    property p_locked;
        @(posedge clk_sys_i) disable iff (rst_i || por_rst_i)
        (cfg_lock_i && wr && sel_rev_class) |=> $stable(class_code) && $stable(revision_number);
    endproperty
    a_locked: assert property (p_locked) else $error("locked field was written");

    property p_no_target_abort;
        @(posedge clk_sys_i) disable iff (rst_i)
        (rd && sel_status) |=> !cfg_rdata_o[16 + dfc_pkg::STS_SIGNALED_ABT];
    endproperty
    a_no_target_abort: assert property (p_no_target_abort) else $error("signaled abort bit not zero");

    // checked at the release edge, before any write can land
    property p_class_por;
        @(posedge clk_sys_i)
        $fell(por_rst_i) |-> class_code == {dfc_pkg::BASE_CLASS_RESET, dfc_pkg::SUBCLASS_RESET,
                                            dfc_pkg::PROG_IF_RESET} && revision_number == REVISION_RESET;
    endproperty
    a_class_por: assert property (p_class_por) else $error("class or revision reset value wrong");

    property p_sticky_keep;
        @(posedge clk_sys_i)
        (rst_i && !por_rst_i && !wr) |=> por_rst_i || ($stable(class_code) && $stable(revision_number));
    endproperty
    a_sticky_keep: assert property (p_sticky_keep) else $error("sticky field lost on reset");

    property p_w1c_keep;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr && sel_status && !status_clr[dfc_pkg::STS_POISON_SEEN] && poisoned_packet_seen_flag)
            |=> poisoned_packet_seen_flag;
    endproperty
    a_w1c_keep: assert property (p_w1c_keep) else $error("write zero cleared flag");

    property p_sys_err_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        (event_i.err_msg_tx && system_error_report_enable_i) |=> signaled_system_error_flag;
    endproperty
    a_sys_err_set: assert property (p_sys_err_set) else $error("system error flag not set");

    property p_cpl_parity_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        (parity_report_enable_i && event_i.poisoned_cpl_rx) |=> master_parity_error_flag;
    endproperty
    a_cpl_parity_set: assert property (p_cpl_parity_set) else $error("parity flag missed completion");

endmodule // dfc_header_status
`default_nettype wire

/* rtl/dfc_lock_byte.sv */
// one lockable byte that keeps its value across all but the power-on reset
`timescale 1ns/1ns
`default_nettype none
module dfc_lock_byte #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       clk_sys_i,
    input  wire logic       por_rst_i,
    input  wire logic       we_i,
    input  wire logic       lock_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      q_o
);
    // only the power-on reset reaches this byte
    always_ff @(posedge clk_sys_i or posedge por_rst_i) begin
        if (por_rst_i) begin
            q_o <= RESET_VAL;
        end else if (we_i && !lock_i) begin
            q_o <= wdata_i;
        end
    end
endmodule // dfc_lock_byte
`default_nettype wire

/* rtl/dfc_pkg.sv */
// package: register map, field positions, reset values and carriers for the dma function header status block
`default_nettype none
package dfc_pkg;

    // ------------------------------------------------------------------
    // register byte offsets as printed
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_FUNCTION_STATUS = 12'h006;
    localparam logic [11:0] OFS_REVISION_NUMBER = 12'h008;
    localparam logic [11:0] OFS_CLASS_CODE      = 12'h009;
    localparam logic [11:0] OFS_CACHE_LINE_SIZE = 12'h00C;
    localparam logic [11:0] OFS_LATENCY_TIMER   = 12'h00D;
    localparam logic [11:0] OFS_HEADER_TYPE     = 12'h00E;

    // dword index of each configuration word (offset bits 11:2)
    localparam logic [9:0]  DW_CMD_STATUS  = OFS_FUNCTION_STATUS[11:2];
    localparam logic [9:0]  DW_REV_CLASS   = OFS_REVISION_NUMBER[11:2];
    localparam logic [9:0]  DW_LINE_HEADER = OFS_CACHE_LINE_SIZE[11:2];

    // byte lane of each register inside its dword
    localparam int LANE_STATUS_LO   = 2;
    localparam int LANE_STATUS_HI   = 3;
    localparam int LANE_REV         = 0;
    localparam int LANE_PROG_IF     = 1;
    localparam int LANE_SUBCLASS    = 2;
    localparam int LANE_BASE_CLASS  = 3;
    localparam int LANE_LINE_SIZE   = 0;
    localparam int LANE_LATENCY     = 1;
    localparam int LANE_HEADER_TYPE = 2;

    // ------------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------------
    localparam int STS_INTX_PENDING  = 3;
    localparam int STS_CAP_LIST      = 4;
    localparam int STS_MASTER_PARITY = 8;
    localparam int STS_SIGNALED_ABT  = 11;
    localparam int STS_RX_CPL_ABORT  = 12;
    localparam int STS_RX_UNSUPP     = 13;
    localparam int STS_SIG_SYS_ERR   = 14;
    localparam int STS_POISON_SEEN   = 15;

    // ------------------------------------------------------------------
    // reset and fixed values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PROG_IF_RESET     = 8'h00;
    localparam logic [7:0]  SUBCLASS_RESET    = 8'h80;
    localparam logic [7:0]  BASE_CLASS_RESET  = 8'h08;
    localparam logic [7:0]  LINE_SIZE_RESET   = 8'h00;
    localparam logic [7:0]  LATENCY_VALUE     = 8'h00;
    localparam logic [7:0]  HEADER_TYPE_VALUE = 8'h80;
    localparam logic [0:0]  CAP_LIST_VALUE    = 1'h1;
    localparam logic [7:0]  BIST_VALUE        = 8'h00;
    localparam logic [31:0] UNMAPPED_VALUE    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [9:0]  dword;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } dfc_cfg_req_type;

    typedef struct packed {
        logic poisoned_cpl_rx;
        logic poisoned_req_tx;
        logic poisoned_tlp_rx;
        logic cpl_abort_rx;
        logic cpl_unsupported_rx;
        logic err_msg_tx;
    } dfc_event_type;

endpackage
`default_nettype wire

/* rtl/dfc_w1c_flag.sv */
// one sticky error flag: hardware sets, software clears by writing one
`timescale 1ns/1ns
`default_nettype none
module dfc_w1c_flag (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    // a set in the clearing cycle wins so no event is lost
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // dfc_w1c_flag
`default_nettype wire
